// >>> lut_dac_defines.svh
`ifndef LUT_DAC_DEFINES_SVH
`define LUT_DAC_DEFINES_SVH

// register offsets within the second upper table
`define OFS_LUT_MODE_CONTROL      8'h80
`define OFS_TEMPERATURE_INDEX     8'h81
`define OFS_MODULATION_DAC_VALUE  8'h82
`define OFS_POWER_REF_DAC_VALUE   8'h83
`define OFS_VOLTAGE_INDEX         8'h84
`define OFS_VIDEO_GAIN_DAC_VALUE  8'h85
`define OFS_PART_IDENTIFIER       8'h86
`define OFS_PART_VERSION          8'h87

// mode register fields
`define MODE_EEPROM_COMMIT_BLOCK  7
`define MODE_VIDEO_DAC_AUTO       4
`define MODE_INDEX_AUTO           3
`define MODE_MODULATION_AUTO      2
`define MODE_POWER_REF_AUTO       1
`define MODE_BIAS_AUTO            0
`define MODE_WRITE_MASK           8'h9f

// reset values
`define RST_LUT_MODE_CONTROL      8'h1f
`define RST_REGISTER              8'h00

// index arithmetic
`define TEMP_INDEX_LOW_DEG        (-40)
`define TEMP_INDEX_HIGH_DEG       102
`define INDEX_OFFSET              8'h80
`define TEMP_INDEX_FLOOR          8'h00
`define TEMP_INDEX_CEIL           8'hc7
`define VOLT_INDEX_SHIFT          11
`define MOD_ADDR_LEAD             1'b1
`define APC_ADDR_LEAD             2'b10
`define VID_ADDR_LEAD             3'b100

`endif

// >>> lut_dac_mode_control.sv
`include "lut_dac_defines.svh"

// Operation
// - mode bit7 set suppresses EEPROM commits of shadowed bytes; clear allows them.
// - video auto off: video DAC host-writable, lookup recalls stop.
// - manually written DAC values reach the output only at bus STOP.
// - index auto off: indexes frozen, host writes them, recall after conversion.
// - modulation and power-reference registers update in the same cycle.
// - modulation auto off: host writes modulation DAC, recalls disabled.
// - power-reference auto off: host writes it, recalls disabled.
// - bias auto off: loop open, bias from manual value; else loop drives.
// - manual bias above ceiling is not applied and raises ceiling alarm.
// - bias readback shows only the value actually applied.
// - temperature index (T+40)/2+80h, clamped to 00h and C7h.
// - modulation address 1,idx[6:0]; power-reference address 1,0,idx[6:1].
// - index writes need level-two password and index auto off.
// - modulation register reloaded from lookup on every temperature conversion when auto.
// - voltage index is monitor four result / 800h + 80h.
// - single table address is 100 then voltage index bits 4..0.
// - double table address is 100, half select, voltage index bits 4..1.
// - video register reloaded on each monitor-four conversion when auto.
// - identification and version read-only, readable with level-two password.
module lut_dac_mode_control #(
  parameter logic [7:0] PART_ID      = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_VERSION = 8'h01  // arbitrary value
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire lut_dac_pkg::reg_access_s  acc,
  input  wire logic                      table_two_sel,
  input  wire logic                      level_two_password,
  input  wire logic                      stop_seen,
  output logic [7:0]                     rd_data,
  output logic                           eeprom_commit_allow,
  input  wire logic                      temp_done,
  input  wire logic [15:0]               temp_value,
  input  wire logic                      monitor_four_done,
  input  wire logic [15:0]               monitor_input_four,
  input  wire logic                      vid_double,
  input  wire logic                      vid_upper,
  output logic [7:0]                     mod_lut_addr,
  output logic [7:0]                     apc_lut_addr,
  output logic [7:0]                     vid_lut_addr,
  input  wire logic [7:0]                mod_lut_data,
  input  wire logic [7:0]                apc_lut_data,
  input  wire logic [7:0]                vid_lut_data,
  input  wire logic                      manual_bias_wr,
  input  wire logic [7:0]                manual_bias_value,
  input  wire logic [7:0]                bias_ceiling,
  input  wire logic [7:0]                loop_bias,
  output logic [7:0]                     modulation_dac,
  output logic [7:0]                     power_reference_dac,
  output logic [7:0]                     video_gain_dac,
  output logic [7:0]                     bias_dac,
  output logic [7:0]                     bias_readback,
  output logic                           bias_ceiling_alarm
);

  lut_dac_pkg::ctrl_state_s st;
  lut_dac_pkg::ctrl_state_s next_st;

  // temperature in whole degrees (upper byte) to lookup index
  function automatic logic [7:0] temp_to_index(input logic [15:0] t);
    logic signed [9:0] deg;
    logic [9:0]        sum;
    deg = 10'(signed'(t[15:8]));
    sum = 10'(deg - 10'(`TEMP_INDEX_LOW_DEG));
    if (deg < 10'(`TEMP_INDEX_LOW_DEG))
      return `TEMP_INDEX_FLOOR;
    else if (deg > 10'(`TEMP_INDEX_HIGH_DEG))
      return `TEMP_INDEX_CEIL;
    else
      return 8'(sum[9:1]) + `INDEX_OFFSET;
  endfunction

  // monitor four result to lookup index
  function automatic logic [7:0] volt_to_index(input logic [15:0] v);
    return 8'(v >> `VOLT_INDEX_SHIFT) + `INDEX_OFFSET;
  endfunction

  // host write to one offset inside this bank, gated by password
  function automatic logic wr_hit(input lut_dac_pkg::reg_access_s a,
                                  input logic sel, input logic pw,
                                  input logic [7:0] ofs);
    return a.valid && a.write && sel && pw && (a.addr == ofs);
  endfunction

  logic wr_mode;
  logic wr_tidx;
  logic wr_vidx;
  logic wr_mod;
  logic wr_apc;
  logic wr_vid;
  logic rd_hit;
  logic bias_over;

  // write decode with auto-bit gating
  always_comb begin
    wr_mode = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_LUT_MODE_CONTROL);
    wr_tidx = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_TEMPERATURE_INDEX)
              && !st.mode[`MODE_INDEX_AUTO];
    wr_vidx = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_VOLTAGE_INDEX)
              && !st.mode[`MODE_INDEX_AUTO];
    wr_mod  = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_MODULATION_DAC_VALUE)
              && !st.mode[`MODE_MODULATION_AUTO];
    wr_apc  = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_POWER_REF_DAC_VALUE)
              && !st.mode[`MODE_POWER_REF_AUTO];
    wr_vid  = wr_hit(acc, table_two_sel, level_two_password,
                     `OFS_VIDEO_GAIN_DAC_VALUE)
              && !st.mode[`MODE_VIDEO_DAC_AUTO];
    rd_hit  = acc.valid && !acc.write && table_two_sel;
    bias_over = manual_bias_value > bias_ceiling;
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.recall_t = temp_done;
    next_st.recall_v = monitor_four_done;
    next_st.bias_alarm = 1'b0;

    if (wr_mode)
      next_st.mode = acc.wdata & `MODE_WRITE_MASK;

    // indexes: conversions in auto, host writes in manual
    if (st.mode[`MODE_INDEX_AUTO]) begin
      if (temp_done)
        next_st.temp_index = temp_to_index(temp_value);
      if (monitor_four_done)
        next_st.volt_index = volt_to_index(monitor_input_four);
    end else begin
      if (wr_tidx)
        next_st.temp_index = acc.wdata;
      if (wr_vidx)
        next_st.volt_index = acc.wdata;
    end

    // outputs follow pending manual values at the bus stop
    if (stop_seen) begin
      if (st.mod_pend) begin
        next_st.mod_out = st.mod_reg;
        next_st.mod_pend = 1'b0;
      end
      if (st.apc_pend) begin
        next_st.apc_out = st.apc_reg;
        next_st.apc_pend = 1'b0;
      end
      if (st.vid_pend) begin
        next_st.vid_out = st.vid_reg;
        next_st.vid_pend = 1'b0;
      end
      if (st.bias_pend) begin
        next_st.bias_out = st.bias_pend_val;
        next_st.bias_pend = 1'b0;
      end
    end

    // temperature recall: both registers in one cycle
    if (st.recall_t) begin
      if (st.mode[`MODE_MODULATION_AUTO]) begin
        next_st.mod_reg = mod_lut_data;
        next_st.mod_out = mod_lut_data;
      end
      if (st.mode[`MODE_POWER_REF_AUTO]) begin
        next_st.apc_reg = apc_lut_data;
        next_st.apc_out = apc_lut_data;
      end
    end

    // voltage recall
    if (st.recall_v && st.mode[`MODE_VIDEO_DAC_AUTO]) begin
      next_st.vid_reg = vid_lut_data;
      next_st.vid_out = vid_lut_data;
    end

    // manual DAC writes, held until the stop
    if (wr_mod) begin
      next_st.mod_reg = acc.wdata;
      next_st.mod_pend = 1'b1;
    end
    if (wr_apc) begin
      next_st.apc_reg = acc.wdata;
      next_st.apc_pend = 1'b1;
    end
    if (wr_vid) begin
      next_st.vid_reg = acc.wdata;
      next_st.vid_pend = 1'b1;
    end

    // bias: closed loop or checked manual value
    if (st.mode[`MODE_BIAS_AUTO]) begin
      next_st.bias_out = loop_bias;
      next_st.bias_pend = 1'b0;
    end else if (manual_bias_wr) begin
      if (bias_over) begin
        next_st.bias_alarm = 1'b1;
      end else begin
        next_st.bias_pend_val = manual_bias_value;
        next_st.bias_pend = 1'b1;
      end
    end

    // read data, zero without password or off the map
    next_st.rd_data = st.rd_data;
    if (rd_hit) begin
      if (!level_two_password)
        next_st.rd_data = `RST_REGISTER;
      else begin
        unique case (acc.addr)
          `OFS_LUT_MODE_CONTROL:     next_st.rd_data = st.mode;
          `OFS_TEMPERATURE_INDEX:    next_st.rd_data = st.temp_index;
          `OFS_MODULATION_DAC_VALUE: next_st.rd_data = st.mod_reg;
          `OFS_POWER_REF_DAC_VALUE:  next_st.rd_data = st.apc_reg;
          `OFS_VOLTAGE_INDEX:        next_st.rd_data = st.volt_index;
          `OFS_VIDEO_GAIN_DAC_VALUE: next_st.rd_data = st.vid_reg;
          `OFS_PART_IDENTIFIER:      next_st.rd_data = PART_ID;
          `OFS_PART_VERSION:         next_st.rd_data = PART_VERSION;
          default:                   next_st.rd_data = `RST_REGISTER;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.mode <= `RST_LUT_MODE_CONTROL;
    end else begin
      st <= next_st;
    end
  end

  // lookup addresses from the index registers
  always_comb begin
    mod_lut_addr = {`MOD_ADDR_LEAD, st.temp_index[6:0]};
    apc_lut_addr = {`APC_ADDR_LEAD, st.temp_index[6:1]};
    if (vid_double)
      vid_lut_addr = {`VID_ADDR_LEAD, vid_upper, st.volt_index[4:1]};
    else
      vid_lut_addr = {`VID_ADDR_LEAD, st.volt_index[4:0]};
  end

  // outputs
  assign rd_data             = st.rd_data;
  assign eeprom_commit_allow = !st.mode[`MODE_EEPROM_COMMIT_BLOCK];
  assign modulation_dac      = st.mod_out;
  assign power_reference_dac = st.apc_out;
  assign video_gain_dac      = st.vid_out;
  assign bias_dac            = st.bias_out;
  assign bias_readback       = st.bias_out;
  assign bias_ceiling_alarm  = st.bias_alarm;

  // checks
  sequence s_mod_manual_write;
    wr_mod && !stop_seen;
  endsequence

  sequence s_bias_rejected;
    !st.mode[`MODE_BIAS_AUTO] && manual_bias_wr && bias_over;
  endsequence

  property p_commit_block;
    @(posedge clk) disable iff (sys_rst)
      wr_mode && acc.wdata[`MODE_EEPROM_COMMIT_BLOCK] |=> !eeprom_commit_allow;
  endproperty
  a_commit_block: assert property (p_commit_block)
    else $error("commit not blocked after mode write");

  property p_mod_waits_stop;
    @(posedge clk) disable iff (sys_rst)
      s_mod_manual_write |=> $stable(modulation_dac) ##1
        ($stable(modulation_dac) || $past(stop_seen)
         || $past(st.recall_t));
  endproperty
  a_mod_waits_stop: assert property (p_mod_waits_stop)
    else $error("modulation output moved before stop");

  property p_mod_at_stop;
    @(posedge clk) disable iff (sys_rst)
      st.mod_pend && stop_seen && !st.recall_t |=>
        modulation_dac == $past(st.mod_reg);
  endproperty
  a_mod_at_stop: assert property (p_mod_at_stop)
    else $error("modulation output not loaded at stop");

  property p_index_frozen;
    @(posedge clk) disable iff (sys_rst)
      !st.mode[`MODE_INDEX_AUTO] && !wr_tidx && !wr_mode |=>
        $stable(st.temp_index);
  endproperty
  a_index_frozen: assert property (p_index_frozen)
    else $error("temperature index changed in manual index mode");

  property p_recall_pair;
    @(posedge clk) disable iff (sys_rst)
      temp_done && st.mode[`MODE_MODULATION_AUTO]
        && st.mode[`MODE_POWER_REF_AUTO] && !wr_mode ##1 !wr_mode |=>
        st.mod_reg == $past(mod_lut_data)
        && st.apc_reg == $past(apc_lut_data);
  endproperty
  a_recall_pair: assert property (p_recall_pair)
    else $error("modulation and reference not recalled together");

  property p_bias_reject;
    @(posedge clk) disable iff (sys_rst)
      s_bias_rejected |=> bias_ceiling_alarm ##1
        ($stable(bias_dac) || $past(stop_seen));
  endproperty
  a_bias_reject: assert property (p_bias_reject)
    else $error("over-ceiling bias not rejected");

  property p_bias_readback;
    @(posedge clk) disable iff (sys_rst)
      !st.mode[`MODE_BIAS_AUTO] && !stop_seen && !wr_mode |=>
        $stable(bias_readback);
  endproperty
  a_bias_readback: assert property (p_bias_readback)
    else $error("bias readback changed without applied value");

  property p_temp_clamp;
    @(posedge clk) disable iff (sys_rst)
      temp_done && st.mode[`MODE_INDEX_AUTO] && !wr_mode
        && $signed(temp_value[15:8]) > `TEMP_INDEX_HIGH_DEG |=>
        st.temp_index == `TEMP_INDEX_CEIL;
  endproperty
  a_temp_clamp: assert property (p_temp_clamp)
    else $error("temperature index not clamped high");

  property p_index_write_ignored;
    @(posedge clk) disable iff (sys_rst)
      st.mode[`MODE_INDEX_AUTO] && !temp_done && !monitor_four_done |=>
        $stable(st.temp_index) && $stable(st.volt_index);
  endproperty
  a_index_write_ignored: assert property (p_index_write_ignored)
    else $error("index changed without conversion in auto mode");

  property p_vid_addr;
    @(posedge clk) disable iff (sys_rst)
      vid_double |-> vid_lut_addr[4] == vid_upper
        && vid_lut_addr[3:0] == st.volt_index[4:1];
  endproperty
  a_vid_addr: assert property (p_vid_addr)
    else $error("double table address wrong");

  property p_vid_recall;
    @(posedge clk) disable iff (sys_rst)
      monitor_four_done && st.mode[`MODE_VIDEO_DAC_AUTO] && !wr_mode
        ##1 !wr_mode
        |=> video_gain_dac == $past(vid_lut_data);
  endproperty
  a_vid_recall: assert property (p_vid_recall)
    else $error("video gain not recalled after conversion");

endmodule

// >>> lut_dac_pkg.sv
package lut_dac_pkg;

  // one byte access handed over by the two-wire slave
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  // all state of the block
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] temp_index;
    logic [7:0] mod_reg;
    logic [7:0] apc_reg;
    logic [7:0] volt_index;
    logic [7:0] vid_reg;
    logic [7:0] mod_out;
    logic [7:0] apc_out;
    logic [7:0] vid_out;
    logic [7:0] bias_out;
    logic [7:0] bias_pend_val;
    logic [7:0] rd_data;
    logic       mod_pend;
    logic       apc_pend;
    logic       vid_pend;
    logic       bias_pend;
    logic       recall_t;
    logic       recall_v;
    logic       bias_alarm;
  } ctrl_state_s;

endpackage

// >>> test_lut_dac_mode_control.sv
`define chk(act, exp) begin \
  comparisons++; \
  if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); \
  end \
end

module test_lut_dac_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_VAL  = 8'h3c; // arbitrary value
  localparam logic [7:0] VER_VAL = 8'h07; // arbitrary value
  logic clk = 0, sys_rst = 1, sel = 1, pw = 1, t_done = 0, m_done = 0;
  logic dbl = 0, upr = 0, mb_wr = 0, stop, commit, alarm, pm, pa, pv, pb;
  logic [15:0] t_val = 0, m_val = 0;
  logic [7:0] mb_val = 0, ceil = 8'h80, loop = 0, rd, ma, aa, va;
  logic [7:0] mod_o, apc_o, vid_o, b_o, b_rb, e_mod, e_apc, e_vid, e_bias;
  logic [7:0] pbv;
  logic [7:0] m [8];
  lut_dac_pkg::reg_access_s acc;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  int tt [6] = '{-55, -41, -40, -39, 102, 103};

  two_wire_host host (.clk(clk), .acc(acc), .stop_seen(stop));

  lut_dac_mode_control #(.PART_ID(ID_VAL), .PART_VERSION(VER_VAL)) dut (
    .clk(clk), .sys_rst(sys_rst), .acc(acc), .table_two_sel(sel),
    .level_two_password(pw), .stop_seen(stop), .rd_data(rd),
    .eeprom_commit_allow(commit), .temp_done(t_done), .temp_value(t_val),
    .monitor_four_done(m_done), .monitor_input_four(m_val), .vid_double(dbl),
    .vid_upper(upr), .mod_lut_addr(ma), .apc_lut_addr(aa),
    .vid_lut_addr(va), .mod_lut_data(ma ^ 8'h3c),
    .apc_lut_data(aa ^ 8'h5b), .vid_lut_data(va ^ 8'ha5),
    .manual_bias_wr(mb_wr), .manual_bias_value(mb_val),
    .bias_ceiling(ceil), .loop_bias(loop), .modulation_dac(mod_o),
    .power_reference_dac(apc_o), .video_gain_dac(vid_o), .bias_dac(b_o),
    .bias_readback(b_rb), .bias_ceiling_alarm(alarm));

  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // write through the host, model applies the access rules
  task automatic wr(input logic [7:0] a, d);
    host.access(1'b1, a, d);
    if (sel && pw) begin
      case (a)
        8'h80: m[0] = d & 8'h9f;
        8'h81: if (!m[0][3]) m[1] = d;
        8'h82: if (!m[0][2]) {m[2], pm} = {d, 1'b1};
        8'h83: if (!m[0][1]) {m[3], pa} = {d, 1'b1};
        8'h84: if (!m[0][3]) m[4] = d;
        8'h85: if (!m[0][4]) {m[5], pv} = {d, 1'b1};
        default: ;
      endcase
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (sel && pw && a[7:3] == 5'b10000)
      e = (a == 8'h86) ? ID_VAL : (a == 8'h87) ? VER_VAL : m[a[2:0]];
    host.access(1'b0, a, 8'h00);
    `chk(rd, e)
  endtask

  task automatic outs();
    `chk(mod_o, e_mod)
    `chk(apc_o, e_apc)
    `chk(vid_o, e_vid)
    `chk(commit, ~m[0][7])
  endtask

  // STOP applies pending manual values
  task automatic stp();
    host.stop();
    if (pm) e_mod = m[2];
    if (pa) e_apc = m[3];
    if (pv) e_vid = m[5];
    if (pb) e_bias = pbv;
    {pm, pa, pv, pb} = 4'h0;
    outs();
    `chk(b_o, e_bias)
    `chk(b_rb, e_bias)
  endtask

  task automatic conv_t(input int t);
    logic [7:0] i;
    i = (t < -40) ? 8'h00 : (t > 102) ? 8'hc7 : 8'((t + 40) / 2 + 128);
    @(negedge clk);
    t_val = {8'(t), 8'h00};
    t_done = 1'b1;
    @(negedge clk);
    t_done = 1'b0;
    if (m[0][3]) m[1] = i;
    `chk(ma, {1'b1, m[1][6:0]})
    `chk(aa, {2'b10, m[1][6:1]})
    @(negedge clk);
    if (m[0][2]) {m[2], e_mod} = {2{{1'b1, m[1][6:0]} ^ 8'h3c}};
    if (m[0][1]) {m[3], e_apc} = {2{{2'b10, m[1][6:1]} ^ 8'h5b}};
    outs();
  endtask

  task automatic conv_v(input logic [15:0] v);
    logic [7:0] i, ea;
    i = 8'(v / 16'h0800 + 16'h0080);
    @(negedge clk);
    m_val = v;
    m_done = 1'b1;
    @(negedge clk);
    m_done = 1'b0;
    if (m[0][3]) m[4] = i;
    ea = dbl ? {3'b100, upr, m[4][4:1]} : {3'b100, m[4][4:0]};
    `chk(va, ea)
    @(negedge clk);
    if (m[0][4]) {m[5], e_vid} = {2{ea ^ 8'ha5}};
    outs();
  endtask

  task automatic mbias(input logic [7:0] v);
    @(negedge clk);
    mb_val = v;
    mb_wr = 1'b1;
    @(negedge clk);
    mb_wr = 1'b0;
    `chk(alarm, 1'(v > ceil))
    if (v <= ceil) {pb, pbv} = {1'b1, v};
  endtask

  // main sequence
  initial begin
    void'($urandom(32'haf7e));
    m = '{default: 8'h00};
    m[0] = 8'h1f;
    {e_mod, e_apc, e_vid, e_bias, pbv} = '0;
    {pm, pa, pv, pb} = 4'h0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int a = 128; a < 136; a++) rd_chk(8'(a));
    // refused writes: auto bits set, read only, no password, wrong table
    wr(8'h81, 8'h55);
    wr(8'h82, 8'h66);
    wr(8'h86, 8'h00);
    pw = 1'b0;
    wr(8'h80, 8'h00);
    rd_chk(8'h80);
    pw = 1'b1;
    sel = 1'b0;
    wr(8'h80, 8'h00);
    sel = 1'b1;
    for (int a = 128; a < 136; a++) rd_chk(8'(a));
    rd_chk(8'h90);
    // automatic indexes and recalls
    foreach (tt[k]) conv_t(tt[k]);
    for (int k = 0; k < 6; k++) conv_t(int'($urandom_range(150)) - 50);
    rd_chk(8'h81);
    for (int k = 0; k < 8; k++) begin
      {dbl, upr} = 2'($urandom);
      conv_v(16'($urandom));
      rd_chk(8'h84);
    end
    // commit block set and cleared
    wr(8'h80, 8'hff);
    rd_chk(8'h80);
    outs();
    wr(8'h80, 8'h1f);
    outs();
    // all manual: outputs wait for STOP, indexes frozen
    wr(8'h80, 8'h00);
    for (int a = 129; a < 134; a++) wr(8'(a), 8'($urandom));
    outs();
    for (int a = 129; a < 134; a++) rd_chk(8'(a));
    stp();
    conv_t(25);
    conv_v(16'h4000);
    rd_chk(8'h81);
    // host index with automatic recall
    wr(8'h80, 8'h17);
    wr(8'h81, 8'($urandom));
    conv_t(0);
    wr(8'h84, 8'($urandom));
    conv_v(16'h0000);
    // manual bias against the ceiling
    wr(8'h80, 8'h1e);
    ceil = 8'($urandom_range(254, 1));
    mbias(ceil + 8'h01);
    stp();
    mbias(ceil);
    `chk(b_o, e_bias)
    stp();
    // closed loop follows the loop value
    wr(8'h80, 8'h1f);
    loop = 8'($urandom);
    @(negedge clk);
    `chk(b_o, loop)
    end_sim();
  end
endmodule

// >>> two_wire_host.sv
// host side of the two-wire bus: one byte access per pulse, STOP as a separate pulse from its own task
module two_wire_host (
  input  wire logic                clk,
  output lut_dac_pkg::reg_access_s acc,
  output logic                     stop_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus before the first access
  initial begin
    acc = '0;
    stop_seen = 1'b0;
  end

  // byte held across one rising edge, then released with inverted lines
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    acc = {1'b1, w, a, d};
    @(negedge clk);
    acc = {1'b0, 1'b0, ~a, ~d};
  endtask

  // end of write cycle
  task automatic stop();
    @(negedge clk);
    stop_seen = 1'b1;
    @(negedge clk);
    stop_seen = 1'b0;
  endtask
endmodule
